// [verilog/flash_self_write_control.v]
// Flash self-write controller: mode register, service decoder and sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_write_map.vh"
// How it works
// - Reset loads the mode control register with 08H, normal mode.
// - Mode register accepts single-bit and whole-byte writes.
// - Bit 2 is read-only and follows the voltage pin continuously.
// - Bit 2 reads 1 when programming voltage present, 0 when absent.
// - Service calls use bank 3: status, function number, block address.
// - Status bits: 7 param, 4 verify, 3 write, 2 erase, 1 blank.
// - Parameter block fields sit at their fixed byte offsets.
// - Function numbers 00H to 60H select the nine services.
// - Byte write copies up to 256 buffer bytes into flash.
// - Set parameters returns 00H normal or 80H on bad times.
// - Byte write advances start address; count 0 means 256.
module flash_self_write_control #(
  parameter FLASH_AW  = 16,
  parameter WAIT_SCALE = 16'h0001,
  parameter [7:0] INFO_CODE = 8'h5A  // Arbitrary identification value.
) (
  input  wire                sys_clk,
  input  wire                rstn,
  input  wire                sfrWr,
  input  wire                sfrBitWr,
  input  wire [2:0]          sfrBit,
  input  wire [15:0]         sfrAddr,
  input  wire [7:0]          sfrWdata,
  output reg  [7:0]          sfrRdata,
  input  wire                vppPin,
  input  wire                pbWr,
  input  wire [4:0]          pbIdx,
  input  wire [7:0]          pbWdata,
  input  wire                bufWr,
  input  wire [7:0]          bufIdx,
  input  wire [7:0]          bufWdata,
  input  wire                callStart,
  input  wire [7:0]          funcNum,
  output reg                 callBusy,
  output reg                 callDone,
  output reg  [7:0]          statusOut,
  output reg  [7:0]          infoOut,
  output reg  [15:0]         startAddrOut,
  output reg                 flashWr,
  output reg  [FLASH_AW-1:0] flashAddr,
  output reg  [7:0]          flashWdata,
  input  wire [7:0]          flashRdata
);
  // ---------------------------------------------------------------
  // State codes
  // ---------------------------------------------------------------
  localparam S_IDLE    = 4'd0;
  localparam S_LOAD    = 4'd1;
  localparam S_RUN     = 4'd2;
  localparam S_WAIT    = 4'd3;
  localparam S_CHECK   = 4'd4;
  localparam S_DONE    = 4'd5;
  localparam S_SETTLE  = 4'd6;
  localparam S_BACK_LO = 4'd7;
  localparam S_BACK_HI = 4'd8;

  reg  [3:0]  state_reg;
  reg  [7:0]  fn_reg;
  reg  [7:0]  status_reg;
  reg  [8:0]  left_reg;
  reg  [7:0]  bufPtr_reg;
  reg  [15:0] addr_reg;
  reg  [7:0]  writeTime_reg;
  reg  [23:0] eraseTime_reg;
  reg  [15:0] wait_reg;
  reg  [4:0]  rdIdx_reg;
  reg  [7:0]  wbuf_reg [0:255];
  reg         vppMeta_reg;
  reg         vppSync_reg;
  reg         envReady_reg;
  wire [7:0]  modeView;
  wire [7:0]  pbData;
  wire        modeWr;
  wire        selfWrite;
  wire        progOk;
  wire        isWriteFn;
  wire        mapped;
  wire        backLo;
  wire        backHi;
  wire        pbWrEn;
  wire [4:0]  pbWrIdx;
  wire [7:0]  pbWrData;
  integer     k;

  // ---------------------------------------------------------------
  // Pin synchroniser and mode register
  // ---------------------------------------------------------------
  // The voltage pin passes two flops before any logic reads it.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      vppMeta_reg <= 1'b0;
      vppSync_reg <= 1'b0;
    end else begin
      vppMeta_reg <= vppPin;
      vppSync_reg <= vppMeta_reg;
    end
  end

  assign mapped = (sfrAddr == `MODE_CTRL_ADDR);
  assign modeWr = sfrWr && mapped;

  mode_ctrl_reg u_mode (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wrEn    (modeWr),
    .bitWr   (sfrBitWr),
    .bitSel  (sfrBit),
    .wrData  (sfrWdata),
    .vppHigh (vppSync_reg),
    .modeReg (modeView)
  );

  // Read data is registered; unmapped addresses read zero.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sfrRdata <= 8'h00;
    end else begin
      sfrRdata <= mapped ? modeView : 8'h00;
    end
  end

  assign selfWrite = modeView[`MODE_SELECT_BIT];
  assign progOk    = selfWrite && modeView[`VOLT_STATUS_BIT];
  assign isWriteFn = (fn_reg == `FN_PREWRITE) || (fn_reg == `FN_ERASE) ||
                     (fn_reg == `FN_WRITEBACK) || (fn_reg == `FN_BYTE_WRITE);

  // ---------------------------------------------------------------
  // Parameter block and write buffer
  // ---------------------------------------------------------------
  // After a byte write the sequencer owns the block's write port for two cycles,
  // so the next call starts where this one stopped.
  assign backLo   = (state_reg == S_BACK_LO);
  assign backHi   = (state_reg == S_BACK_HI);
  assign pbWrEn   = pbWr || backLo || backHi;
  assign pbWrIdx  = backLo ? `PB_START_LO : (backHi ? `PB_START_HI : pbIdx);
  assign pbWrData = backLo ? addr_reg[7:0] : (backHi ? addr_reg[15:8] : pbWdata);

  param_block #(.DEPTH(32)) u_pb (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wrEn    (pbWrEn),
    .wrIdx   (pbWrIdx),
    .wrData  (pbWrData),
    .rdIdx   (rdIdx_reg),
    .rdData  (pbData)
  );

  // The write buffer is loaded by the CPU before a byte write call.
  always @(posedge sys_clk) begin
    if (bufWr) begin
      wbuf_reg[bufIdx] <= bufWdata;
    end
  end

  // ---------------------------------------------------------------
  // Service sequencer
  // ---------------------------------------------------------------
  // One call runs at a time: load fields, operate, report status.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= S_IDLE;
      fn_reg        <= `FN_INIT;
      status_reg    <= `ST_OK;
      left_reg      <= 9'd0;
      bufPtr_reg    <= 8'h00;
      addr_reg      <= 16'h0000;
      writeTime_reg <= 8'h00;
      eraseTime_reg <= 24'h000000;
      wait_reg      <= 16'h0000;
      rdIdx_reg     <= 5'h00;
      envReady_reg  <= 1'b0;
      callBusy      <= 1'b0;
      callDone      <= 1'b0;
      statusOut     <= `ST_OK;
      infoOut       <= 8'h00;
      startAddrOut  <= 16'h0000;
      flashWr       <= 1'b0;
      flashAddr     <= {FLASH_AW{1'b0}};
      flashWdata    <= 8'h00;
    end else begin
      callDone <= 1'b0;
      flashWr  <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (callStart) begin
            fn_reg     <= funcNum;
            status_reg <= `ST_OK;
            callBusy   <= 1'b1;
            rdIdx_reg  <= `PB_START_LO;
            state_reg  <= S_LOAD;
          end
        end
        S_LOAD: begin
          // Walk offsets 2..10 and 14..15, one byte per cycle.
          case (rdIdx_reg)
            `PB_START_LO:   addr_reg[7:0]        <= pbData;
            `PB_START_HI:   addr_reg[15:8]       <= pbData;
            `PB_COUNT:      left_reg  <= (pbData == 8'h00) ? 9'd256 : {1'b0, pbData};
            `PB_WRITE_TIME: writeTime_reg        <= pbData;
            `PB_ERASE_T0:   eraseTime_reg[7:0]   <= pbData;
            `PB_ERASE_T1:   eraseTime_reg[15:8]  <= pbData;
            `PB_ERASE_T2:   eraseTime_reg[23:16] <= pbData;
            `PB_BUF_LO:     bufPtr_reg           <= pbData;
            default:        rdIdx_reg            <= rdIdx_reg;
          endcase
          if (rdIdx_reg == `PB_BUF_HI) begin
            state_reg <= S_RUN;
          end else if (rdIdx_reg == `PB_ERASE_T2) begin
            rdIdx_reg <= `PB_BUF_LO;
          end else begin
            rdIdx_reg <= rdIdx_reg + 5'd1;
          end
        end
        S_RUN: begin
          state_reg <= S_DONE;
          if (isWriteFn && !progOk) begin
            status_reg <= (fn_reg == `FN_ERASE) ? `ST_ERASE_ERR : `ST_WRITE_ERR;
          end else begin
            case (fn_reg)
              `FN_INIT: envReady_reg <= 1'b1;
              `FN_SET_PARAMS: begin
                // Write time must be a nonzero multiple of 20H up to A0H.
                if (writeTime_reg == 8'h00 || writeTime_reg > `WT_MAX ||
                    writeTime_reg[4:0] != 5'h00 || eraseTime_reg == 24'h0) begin
                  status_reg <= `ST_PARAM_ERR;
                end
              end
              `FN_READ_INFO: infoOut <= INFO_CODE;
              `FN_BLANK_CHECK, `FN_VERIFY, `FN_ERASE, `FN_WRITEBACK,
              `FN_PREWRITE, `FN_BYTE_WRITE: begin
                if (!envReady_reg) begin
                  status_reg <= `ST_PARAM_ERR;
                end else begin
                  if (fn_reg != `FN_BYTE_WRITE) begin
                    left_reg <= 9'd1;
                  end
                  wait_reg  <= WAIT_SCALE;
                  state_reg <= S_WAIT;
                end
              end
              default: status_reg <= `ST_PARAM_ERR;
            endcase
          end
        end
        S_WAIT: begin
          // Stand-in for the array's program or erase time.
          if (wait_reg <= 16'h0001) begin
            state_reg <= S_SETTLE;
            flashAddr <= addr_reg[FLASH_AW-1:0];
            if (fn_reg == `FN_BYTE_WRITE) begin
              flashWr    <= 1'b1;
              flashWdata <= wbuf_reg[bufPtr_reg];
            end else if (fn_reg == `FN_PREWRITE) begin
              flashWr    <= 1'b1;
              flashWdata <= `PREWRITE_BYTE;
            end else if (fn_reg == `FN_ERASE) begin
              flashWr    <= 1'b1;
              flashWdata <= `BLANK_BYTE;
            end
          end else begin
            wait_reg <= wait_reg - 16'h0001;
          end
        end
        S_CHECK: begin
          // Compare the array against the expected byte for blank check, verify and erase.
          case (fn_reg)
            `FN_BLANK_CHECK: if (flashRdata != `BLANK_BYTE) status_reg <= `ST_BLANK_ERR;
            `FN_VERIFY:      if (flashRdata != flashWdata) status_reg <= `ST_VERIFY_ERR;
            `FN_ERASE:       if (flashRdata != `BLANK_BYTE) status_reg <= `ST_ERASE_ERR;
            default:         status_reg <= status_reg;
          endcase
          if (fn_reg == `FN_BYTE_WRITE) begin
            addr_reg   <= addr_reg + 16'h0001;
            bufPtr_reg <= bufPtr_reg + 8'h01;
          end
          left_reg <= left_reg - 9'd1;
          if (left_reg <= 9'd1) begin
            state_reg <= (fn_reg == `FN_BYTE_WRITE) ? S_BACK_LO : S_DONE;
          end else begin
            wait_reg  <= WAIT_SCALE;
            state_reg <= S_WAIT;
          end
        end
        S_DONE: begin
          statusOut    <= status_reg;
          startAddrOut <= addr_reg;
          callBusy     <= 1'b0;
          callDone     <= 1'b1;
          state_reg    <= S_IDLE;
        end
        S_SETTLE: begin
          // One cycle lets a write land before the array is read back.
          state_reg <= S_CHECK;
        end
        S_BACK_LO: begin
          // Low byte of the advanced start address goes back to the block.
          state_reg <= S_BACK_HI;
        end
        S_BACK_HI: begin
          state_reg <= S_DONE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [verilog/flash_self_write_map.vh]
// Constants for the flash self-write control block.
`ifndef FLASH_SELF_WRITE_MAP_VH
`define FLASH_SELF_WRITE_MAP_VH
`define MODE_CTRL_ADDR   16'hFF89
`define MODE_CTRL_RESET  8'h08
`define MODE_SELECT_BIT  0
`define VOLT_STATUS_BIT  2
`define MODE_FIXED_MASK  8'hFA
`define FN_INIT          8'h00
`define FN_SET_PARAMS    8'h01
`define FN_READ_INFO     8'h02
`define FN_BLANK_CHECK   8'h10
`define FN_PREWRITE      8'h20
`define FN_ERASE         8'h30
`define FN_WRITEBACK     8'h40
`define FN_BYTE_WRITE    8'h50
`define FN_VERIFY        8'h60
`define ST_OK            8'h00
`define ST_PARAM_ERR     8'h80
`define ST_VERIFY_ERR    8'h10
`define ST_WRITE_ERR     8'h08
`define ST_ERASE_ERR     8'h04
`define ST_BLANK_ERR     8'h02
`define PB_START_LO      5'h02
`define PB_START_HI      5'h03
`define PB_COUNT         5'h06
`define PB_WRITE_TIME    5'h07
`define PB_ERASE_T0      5'h08
`define PB_ERASE_T1      5'h09
`define PB_ERASE_T2      5'h0A
`define PB_WB_T0         5'h0B
`define PB_BUF_LO        5'h0E
`define PB_BUF_HI        5'h0F
`define PB_TOTALS_LO     5'h10
`define PB_TOTALS_HI     5'h11
`define WT_STEP          8'h20
`define WT_MAX           8'hA0
`define BLANK_BYTE       8'hFF
`define PREWRITE_BYTE    8'h00
`endif

// [verilog/mode_ctrl_reg.v]
// Flash programming mode control register with live voltage status bit.
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_write_map.vh"
module mode_ctrl_reg (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       wrEn,
  input  wire       bitWr,
  input  wire [2:0] bitSel,
  input  wire [7:0] wrData,
  input  wire       vppHigh,
  output reg  [7:0] modeReg
);
  reg  [7:0] store_reg;
  wire [7:0] merged;
  // A bit write changes one bit; a byte write replaces the byte.
  assign merged = bitWr ? ((store_reg & ~(8'h01 << bitSel)) |
                           ({7'h00, wrData[0]} << bitSel)) : wrData;
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Reset loads normal mode; the stored copy of bit 2 is never read back.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      store_reg <= `MODE_CTRL_RESET;
    end else if (wrEn) begin
      store_reg <= merged;
    end
  end
  // Readback view: bit 2 always mirrors the synchronised pin.
  always @* begin
    modeReg = store_reg;
    modeReg[`VOLT_STATUS_BIT] = vppHigh;
  end
endmodule
`default_nettype wire

// [verilog/param_block.v]
// Thirty-two byte parameter block storage with one write and one read port.
`timescale 1ns/1ps
`default_nettype none
module param_block #(
  parameter DEPTH = 32
) (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       wrEn,
  input  wire [4:0] wrIdx,
  input  wire [7:0] wrData,
  input  wire [4:0] rdIdx,
  output wire [7:0] rdData
);
  reg [7:0] mem_reg [0:DEPTH-1];
  genvar i;
  // Each entry clears at reset and loads on an indexed write.
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
      always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          mem_reg[i] <= 8'h00;
        end else if (wrEn && (wrIdx == i)) begin
          mem_reg[i] <= wrData;
        end
      end
    end
  endgenerate
  assign rdData = mem_reg[rdIdx];
endmodule
`default_nettype wire

// [verif/flash_array_model.sv]
// Behavioural flash array that answers the controller's byte port.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  input  wire logic        sys_clk,
  input  wire logic        flashWr,
  input  wire logic [15:0] flashAddr,
  input  wire logic [7:0]  flashWdata,
  output wire logic [7:0]  flashRdata
);
  logic [7:0] mem [0:65535];
  // An array that was never written reads as erased bytes.
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hFF;
    end
  end
  // Stores on a write strobe; read data follows the address within the cycle.
  always @(posedge sys_clk) begin
    if (flashWr) begin
      mem[flashAddr] <= flashWdata;
    end
  end
  assign flashRdata = mem[flashAddr];
endmodule
`default_nettype wire

// [verif/flash_self_write_control_sva.sv]
// Port-level assertions for the flash self-write controller.
`timescale 1ns/1ps
`default_nettype none
module flash_self_write_control_chk (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        sfrWr,
  input wire logic        sfrBitWr,
  input wire logic [15:0] sfrAddr,
  input wire logic [7:0]  sfrWdata,
  input wire logic [7:0]  sfrRdata,
  input wire logic        vppPin,
  input wire logic        callStart,
  input wire logic        callBusy,
  input wire logic        callDone,
  input wire logic [7:0]  statusOut,
  input wire logic        flashWr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Fixed bits of the mode register are expected at their reset pattern; a write can change them.
  fixed_bits_a: assert property (sfrAddr == 16'hFF89 |=> sfrRdata[7:3] == 5'h01 && !sfrRdata[1])
    else $error("fixed mode bits changed");
  // The voltage bit follows a steady pin level.
  volt_track_a: assert property ((sfrAddr == 16'hFF89 && $stable(vppPin))[*5]
    |-> sfrRdata[2] == vppPin) else $error("voltage bit not tracking pin");
  mode_write_a: assert property (sfrWr && !sfrBitWr && sfrAddr == 16'hFF89
    ##1 sfrAddr == 16'hFF89 && !sfrWr |=> sfrRdata[0] == $past(sfrWdata[0], 2))
    else $error("mode select byte write lost");
  done_pulse_a: assert property (callDone |=> !callDone)
    else $error("done longer than one cycle");
  call_take_a: assert property (callStart && !callBusy |=> callBusy)
    else $error("idle call not taken");
  call_bound_a: assert property ($rose(callBusy) |-> ##[10:1000] callDone)
    else $error("service never completed");
  flash_busy_a: assert property (flashWr |-> callBusy)
    else $error("flash written outside a service");
  status_hold_a: assert property (!callDone |-> $stable(statusOut))
    else $error("status changed without done");
endmodule
bind flash_self_write_control flash_self_write_control_chk u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .sfrWr(sfrWr), .sfrBitWr(sfrBitWr),
  .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .vppPin(vppPin),
  .callStart(callStart), .callBusy(callBusy), .callDone(callDone),
  .statusOut(statusOut), .flashWr(flashWr));
`default_nettype wire

// [verif/flash_self_write_control_tb.sv]
// Self-checking bench for the flash self-write controller.
`timescale 1ns/1ps
`default_nettype none
module flash_self_write_control_tb;
  logic sys_clk = 0, rstn = 0, sfrWr = 0, sfrBitWr = 0, vppPin = 0;
  logic pbWr = 0, bufWr = 0, callStart = 0, callBusy, callDone, flashWr;
  logic [2:0] sfrBit = 0;
  logic [4:0] pbIdx = 0;
  logic [15:0] sfrAddr = 16'hFF89, startAddrOut, flashAddr;
  logic [7:0] sfrWdata = 0, sfrRdata, pbWdata = 0, bufIdx = 0, bufWdata = 0;
  logic [7:0] funcNum = 0, statusOut, infoOut, flashWdata, flashRdata;
  int fails = 0, num_checks = 0;
  always #2 sys_clk = ~sys_clk;
  flash_self_write_control #(.INFO_CODE(8'h3C)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .sfrWr(sfrWr), .sfrBitWr(sfrBitWr), .sfrBit(sfrBit), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .vppPin(vppPin), .pbWr(pbWr),
    .pbIdx(pbIdx), .pbWdata(pbWdata), .bufWr(bufWr), .bufIdx(bufIdx),
    .bufWdata(bufWdata), .callStart(callStart), .funcNum(funcNum),
    .callBusy(callBusy), .callDone(callDone), .statusOut(statusOut),
    .infoOut(infoOut), .startAddrOut(startAddrOut), .flashWr(flashWr),
    .flashAddr(flashAddr), .flashWdata(flashWdata), .flashRdata(flashRdata));
  flash_array_model i_flash (.sys_clk(sys_clk), .flashWr(flashWr),
    .flashAddr(flashAddr), .flashWdata(flashWdata), .flashRdata(flashRdata));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One register write; the strobe drops at the edge that takes it.
  task automatic sfr_wr(input logic bw, input logic [2:0] b, input logic [7:0] d);
    @(posedge sys_clk);
    sfrWr <= 1'b1;
    sfrBitWr <= bw;
    sfrBit <= b;
    sfrWdata <= d;
    @(posedge sys_clk);
    sfrWr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfrAddr <= a;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(sfrRdata, e);
    @(posedge sys_clk);
    sfrAddr <= 16'hFF89;
  endtask
  task automatic pbw(input logic [4:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    pbWr <= 1'b1;
    pbIdx <= i;
    pbWdata <= d;
    @(posedge sys_clk);
    pbWr <= 1'b0;
  endtask
  // Starts a service and waits a bounded time for its done pulse.
  task automatic call(input logic [7:0] f, input logic [7:0] es);
    int n;
    n = 0;
    @(posedge sys_clk);
    callStart <= 1'b1;
    funcNum <= f;
    @(posedge sys_clk);
    callStart <= 1'b0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (callDone !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fails++;
      $display("unexpected at %0t: service %h timed out", $time, f);
    end
    chk(statusOut, es);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(16'hFF89, 8'h08);
    rd(16'hFF88, 8'h00);
    vppPin <= 1'b1;
    rd(16'hFF89, 8'h0C);
    sfr_wr(1'b0, 3'h0, 8'h09);
    rd(16'hFF89, 8'h0D);
    sfr_wr(1'b1, 3'h2, 8'h00);
    rd(16'hFF89, 8'h0D);
    sfr_wr(1'b1, 3'h0, 8'h00);
    rd(16'hFF89, 8'h0C);
    vppPin <= 1'b0;
    rd(16'hFF89, 8'h08);
  endtask
  task automatic t_refuse;
    call(8'h00, 8'h00);
    call(8'h50, 8'h08);
    call(8'h30, 8'h04);
    sfr_wr(1'b0, 3'h0, 8'h09);
    call(8'h50, 8'h08);
  endtask
  task automatic t_params;
    pbw(5'h08, 8'hA2);
    pbw(5'h09, 8'h07);
    pbw(5'h0B, 8'hA1);
    pbw(5'h0C, 8'h07);
    pbw(5'h0D, 8'h00);
    pbw(5'h0A, 8'h00);
    for (int w = 1; w <= 5; w++) begin
      pbw(5'h07, 8'(w * 32));
      call(8'h01, 8'h00);
    end
    pbw(5'h07, 8'h30);
    call(8'h01, 8'h80);
    pbw(5'h07, 8'h20);
    pbw(5'h08, 8'h00);
    pbw(5'h09, 8'h00);
    call(8'h01, 8'h80);
    pbw(5'h08, 8'hA2);
    call(8'h01, 8'h00);
  endtask
  task automatic t_write;
    vppPin <= 1'b1;
    rd(16'hFF89, 8'h0D);
    pbw(5'h02, 8'h00);
    pbw(5'h03, 8'h20);
    pbw(5'h06, 8'h00);
    pbw(5'h0E, 8'h00);
    for (int i = 0; i < 256; i++) begin
      @(posedge sys_clk);
      bufWr <= 1'b1;
      bufIdx <= 8'(i);
      bufWdata <= 8'(i) ^ 8'hA5;
    end
    @(posedge sys_clk);
    bufWr <= 1'b0;
    call(8'h50, 8'h00);
    chk(startAddrOut, 16'h2100);
    for (int i = 0; i < 256; i++) begin
      chk(i_flash.mem[16'h2000 + i], 8'(i) ^ 8'hA5);
    end
    pbw(5'h06, 8'h03);
    pbw(5'h0E, 8'h10);
    call(8'h50, 8'h00);
    chk(startAddrOut, 16'h2103);
    chk(i_flash.mem[16'h2100], 8'hB5);
  endtask
  task automatic t_funcs;
    call(8'h03, 8'h80);
    call(8'h02, 8'h00);
    chk(infoOut, 8'h3C);
    pbw(5'h02, 8'h00);
    pbw(5'h03, 8'h20);
    call(8'h10, 8'h02);
    pbw(5'h03, 8'h22);
    call(8'h10, 8'h00);
    call(8'h20, 8'h00);
    call(8'h60, 8'h00);
    pbw(5'h03, 8'h23);
    call(8'h60, 8'h10);
    pbw(5'h03, 8'h22);
    call(8'h10, 8'h02);
    call(8'h30, 8'h00);
    call(8'h10, 8'h00);
    call(8'h40, 8'h00);
    sfr_wr(1'b0, 3'h0, 8'h08);
    rd(16'hFF89, 8'h0C);
    call(8'h30, 8'h04);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run of under two thousand cycles.
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_refuse();
    t_params();
    t_write();
    t_funcs();
    finish_test();
  end
endmodule
`default_nettype wire
